// ---- inc/gpgh_consts.vh ----
// Register offsets, field positions and reset values of the two-port GPIO.
`ifndef GPGH_CONSTS_VH
`define GPGH_CONSTS_VH

// ============================================================
// Register word offsets (byte addresses)
`define GPGH_OFF_SMALL_PINS   8'h00
`define GPGH_OFF_SMALL_LATCH  8'h04
`define GPGH_OFF_SMALL_DIR    8'h08
`define GPGH_OFF_WIDE_PINS    8'h0c
`define GPGH_OFF_WIDE_LATCH   8'h10
`define GPGH_OFF_WIDE_DIR     8'h14
`define GPGH_OFF_ANALOG_CFG   8'h18
`define GPGH_OFF_MEM_CTRL     8'h1c

// ============================================================
// Reset values
`define GPGH_RST_SMALL_DIR    5'h1f
`define GPGH_RST_WIDE_DIR     8'hff
`define GPGH_RST_LATCH        8'h00
`define GPGH_RST_SMALL_LATCH  5'h00
`define GPGH_RST_ANALOG_CFG   6'h00
`define GPGH_RST_MEM_CTRL     8'h00

// ============================================================
// Field positions and codes
`define GPGH_PCFG_MSB         3
`define GPGH_PCFG_LSB         0
`define GPGH_PCFG_ALL_DIGITAL 4'hf
`define GPGH_MEM_BUS_OFF_BIT  7
`define GPGH_MEM_CTRL_MASK    8'hb3

`endif

// ---- hw/gpgh_port.v ----
// Five-bit and eight-bit GPIO ports with peripheral and memory-bus muxing.
`timescale 1ns/1ps
`include "gpgh_consts.vh"

module gpgh_port
#(
    parameter SMALL_W = 5,
    parameter WIDE_W  = 8
)
(
    input  wire                clk_i,
    input  wire                rst_i,
    input  wire                cyc_i,
    input  wire                stb_i,
    input  wire                we_i,
    input  wire [7:0]          adr_i,
    input  wire [3:0]          sel_i,
    input  wire [31:0]         dat_i,
    output wire [31:0]         dat_o,
    output wire                ack_o,
    input  wire [SMALL_W-1:0]  small_pin_i,
    output wire [SMALL_W-1:0]  small_pin_o,
    output wire [SMALL_W-1:0]  small_pin_oe_n_o,
    input  wire [WIDE_W-1:0]   wide_pin_i,
    output wire [WIDE_W-1:0]   wide_pin_o,
    output wire [WIDE_W-1:0]   wide_pin_oe_n_o,
    input  wire [SMALL_W-1:0]  periph_force_out_i,
    input  wire [SMALL_W-1:0]  periph_force_in_i,
    input  wire [SMALL_W-1:0]  periph_dout_i,
    output wire [SMALL_W-1:0]  periph_din_o,
    input  wire [3:0]          ext_address_high_bits_i,
    output wire [3:0]          analog_inputs_upper_o,
    output wire [3:0]          analog_cfg_pcfg_o,
    output wire                ext_bus_enabled_o
);

// ============================================================
// Register select codes
localparam [3:0] SEL_SMALL_PINS  = 4'h0;
localparam [3:0] SEL_SMALL_LATCH = 4'h1;
localparam [3:0] SEL_SMALL_DIR   = 4'h2;
localparam [3:0] SEL_WIDE_PINS   = 4'h3;
localparam [3:0] SEL_WIDE_LATCH  = 4'h4;
localparam [3:0] SEL_WIDE_DIR    = 4'h5;
localparam [3:0] SEL_ANALOG_CFG  = 4'h6;
localparam [3:0] SEL_MEM_CTRL    = 4'h7;
localparam [3:0] SEL_NONE        = 4'hf;

// ============================================================
// Registers
reg  [SMALL_W-1:0] small_dir_ff;
reg  [SMALL_W-1:0] small_latch_ff;
reg  [WIDE_W-1:0]  wide_dir_ff;
reg  [WIDE_W-1:0]  wide_latch_ff;
reg  [5:0]         analog_cfg_ff;
reg  [7:0]         mem_ctrl_ff;
reg  [SMALL_W-1:0] small_meta_ff;
reg  [SMALL_W-1:0] small_sync_ff;
reg  [WIDE_W-1:0]  wide_meta_ff;
reg  [WIDE_W-1:0]  wide_sync_ff;
reg                ack_ff;
reg  [31:0]        rdata_ff;
reg  [31:0]        nxt_rdata;
reg  [SMALL_W-1:0] nxt_small_dir;
reg  [SMALL_W-1:0] nxt_small_latch;
reg  [WIDE_W-1:0]  nxt_wide_dir;
reg  [WIDE_W-1:0]  nxt_wide_latch;
reg  [5:0]         nxt_analog_cfg;
reg  [7:0]         nxt_mem_ctrl;
wire               nxt_ack;

wire               req_new;
wire [3:0]         reg_sel;
wire               wr_go;
wire [3:0]         pcfg;
wire               upper_analog;
wire               lower_bus;
wire [SMALL_W-1:0] small_drive;
wire [WIDE_W-1:0]  wide_drive;
wire [WIDE_W-1:0]  wide_out;
wire [WIDE_W-1:0]  wide_read;

// ============================================================
// Address decode
// Read and write share one decode; a write to either pins offset
// lands in that port's latch, and mem_ctrl_ff keeps only the bits set in 8'hb3.
function [3:0] reg_index;
    input [7:0] adr;
    begin
        case (adr & 8'hfc)
            `GPGH_OFF_SMALL_PINS:  reg_index = SEL_SMALL_PINS;
            `GPGH_OFF_SMALL_LATCH: reg_index = SEL_SMALL_LATCH;
            `GPGH_OFF_SMALL_DIR:   reg_index = SEL_SMALL_DIR;
            `GPGH_OFF_WIDE_PINS:   reg_index = SEL_WIDE_PINS;
            `GPGH_OFF_WIDE_LATCH:  reg_index = SEL_WIDE_LATCH;
            `GPGH_OFF_WIDE_DIR:    reg_index = SEL_WIDE_DIR;
            `GPGH_OFF_ANALOG_CFG:  reg_index = SEL_ANALOG_CFG;
            `GPGH_OFF_MEM_CTRL:    reg_index = SEL_MEM_CTRL;
            default:               reg_index = SEL_NONE;
        endcase
    end
endfunction

// ============================================================
// Pin synchronisers
// Pins are asynchronous to clk_i, so two flops precede any reader.
always @(posedge clk_i)
begin
    if (rst_i)
    begin
        small_meta_ff <= {SMALL_W{1'b0}};
        small_sync_ff <= {SMALL_W{1'b0}};
        wide_meta_ff  <= {WIDE_W{1'b0}};
        wide_sync_ff  <= {WIDE_W{1'b0}};
    end
    else
    begin
        small_meta_ff <= small_pin_i;
        small_sync_ff <= small_meta_ff;
        wide_meta_ff  <= wide_pin_i;
        wide_sync_ff  <= wide_meta_ff;
    end
end

// ============================================================
// Pin function selection
assign pcfg         = analog_cfg_ff[`GPGH_PCFG_MSB:`GPGH_PCFG_LSB];
assign upper_analog = (pcfg != `GPGH_PCFG_ALL_DIGITAL);
assign lower_bus    = ~mem_ctrl_ff[`GPGH_MEM_BUS_OFF_BIT];

// Overrides are applied here only, never into small_dir_ff.
// Forcing to input wins over forcing to output if both are asserted.
assign small_drive = (~small_dir_ff | periph_force_out_i)
                     & ~periph_force_in_i;
assign small_pin_o = (small_latch_ff & ~periph_force_out_i)
                     | (periph_dout_i & periph_force_out_i);
assign small_pin_oe_n_o = ~small_drive;
assign periph_din_o     = small_sync_ff;

// Upper pins in analog mode never drive and read as zero.
assign wide_drive[7:4] = upper_analog ? 4'h0 : ~wide_dir_ff[7:4];
assign wide_drive[3:0] = lower_bus ? 4'hf : ~wide_dir_ff[3:0];
assign wide_out[7:4]   = wide_latch_ff[7:4];
assign wide_out[3:0]   = lower_bus ? ext_address_high_bits_i
                                   : wide_latch_ff[3:0];
assign wide_pin_o      = wide_out;
assign wide_pin_oe_n_o = ~wide_drive;
assign wide_read[7:4]  = upper_analog ? 4'h0 : wide_sync_ff[7:4];
assign wide_read[3:0]  = wide_sync_ff[3:0];
assign analog_inputs_upper_o = upper_analog ? wide_sync_ff[7:4] : 4'h0;
assign analog_cfg_pcfg_o     = pcfg;
assign ext_bus_enabled_o     = lower_bus;

// ============================================================
// Wishbone slave
// Ack comes one cycle after the strobe; writes land at the ack edge.
assign req_new = cyc_i & stb_i & ~ack_ff;
assign nxt_ack = req_new;
assign reg_sel = reg_index(adr_i);
assign wr_go   = cyc_i & stb_i & we_i & ack_ff & sel_i[0];
assign ack_o   = ack_ff;
assign dat_o   = rdata_ff;

// Read data is captured at the request edge, so a pin change that
// lands during the ack cycle shows up only in the next read.
always @*
begin
    nxt_rdata = 32'h0000_0000;
    case (reg_sel)
        SEL_SMALL_PINS:
        begin
            nxt_rdata[SMALL_W-1:0] = small_sync_ff;
        end
        SEL_SMALL_LATCH:
        begin
            nxt_rdata[SMALL_W-1:0] = small_latch_ff;
        end
        SEL_SMALL_DIR:
        begin
            nxt_rdata[SMALL_W-1:0] = small_dir_ff;
        end
        SEL_WIDE_PINS:
        begin
            nxt_rdata[WIDE_W-1:0] = wide_read;
        end
        SEL_WIDE_LATCH:
        begin
            nxt_rdata[WIDE_W-1:0] = wide_latch_ff;
        end
        SEL_WIDE_DIR:
        begin
            nxt_rdata[WIDE_W-1:0] = wide_dir_ff;
        end
        SEL_ANALOG_CFG:
        begin
            nxt_rdata[5:0] = analog_cfg_ff;
        end
        SEL_MEM_CTRL:
        begin
            nxt_rdata[7:0] = mem_ctrl_ff;
        end
        default:
        begin
            nxt_rdata = 32'h0000_0000;
        end
    endcase
end

always @(posedge clk_i)
begin
    if (rst_i)
    begin
        ack_ff   <= 1'b0;
        rdata_ff <= 32'h0000_0000;
    end
    else
    begin
        ack_ff <= nxt_ack;
        if (req_new)
        begin
            rdata_ff <= nxt_rdata;
        end
    end
end

// ============================================================
// Register next values
// Only software writes reach the direction registers; peripheral
// overrides act on the pin drivers alone.
always @*
begin
    nxt_small_dir   = small_dir_ff;
    nxt_small_latch = small_latch_ff;
    nxt_wide_dir    = wide_dir_ff;
    nxt_wide_latch  = wide_latch_ff;
    nxt_analog_cfg  = analog_cfg_ff;
    nxt_mem_ctrl    = mem_ctrl_ff;
    if (wr_go)
    begin
        case (reg_sel)
            SEL_SMALL_PINS,
            SEL_SMALL_LATCH:
            begin
                nxt_small_latch = dat_i[SMALL_W-1:0];
            end
            SEL_SMALL_DIR:
            begin
                nxt_small_dir = dat_i[SMALL_W-1:0];
            end
            SEL_WIDE_PINS,
            SEL_WIDE_LATCH:
            begin
                nxt_wide_latch = dat_i[WIDE_W-1:0];
            end
            SEL_WIDE_DIR:
            begin
                nxt_wide_dir = dat_i[WIDE_W-1:0];
            end
            SEL_ANALOG_CFG:
            begin
                nxt_analog_cfg = dat_i[5:0];
            end
            SEL_MEM_CTRL:
            begin
                nxt_mem_ctrl = dat_i[7:0] & `GPGH_MEM_CTRL_MASK;
            end
            default:
            begin
                nxt_mem_ctrl = mem_ctrl_ff;
            end
        endcase
    end
end

// ============================================================
// Register state
always @(posedge clk_i)
begin
    if (rst_i)
    begin
        small_dir_ff   <= `GPGH_RST_SMALL_DIR;
        small_latch_ff <= `GPGH_RST_SMALL_LATCH;
        wide_dir_ff    <= `GPGH_RST_WIDE_DIR;
        wide_latch_ff  <= `GPGH_RST_LATCH;
        analog_cfg_ff  <= `GPGH_RST_ANALOG_CFG;
        mem_ctrl_ff    <= `GPGH_RST_MEM_CTRL;
    end
    else
    begin
        small_dir_ff   <= nxt_small_dir;
        small_latch_ff <= nxt_small_latch;
        wide_dir_ff    <= nxt_wide_dir;
        wide_latch_ff  <= nxt_wide_latch;
        analog_cfg_ff  <= nxt_analog_cfg;
        mem_ctrl_ff    <= nxt_mem_ctrl;
    end
end

endmodule

// ---- sim/gpgh_asserts.sv ----
// Checker on the pins and bus handshake of the two-port GPIO.
`timescale 1ns/1ps
module gpgh_asserts
#(parameter SMALL_W = 5, parameter WIDE_W = 8)
(
    input wire               clk_i,
    input wire               rst_i,
    input wire               cyc_i,
    input wire               stb_i,
    input wire               ack_o,
    input wire [SMALL_W-1:0] small_pin_i,
    input wire [SMALL_W-1:0] small_pin_o,
    input wire [SMALL_W-1:0] small_pin_oe_n_o,
    input wire [SMALL_W-1:0] periph_force_out_i,
    input wire [SMALL_W-1:0] periph_force_in_i,
    input wire [SMALL_W-1:0] periph_dout_i,
    input wire [SMALL_W-1:0] periph_din_o,
    input wire [WIDE_W-1:0]  wide_pin_o,
    input wire [WIDE_W-1:0]  wide_pin_oe_n_o,
    input wire [3:0]         ext_address_high_bits_i,
    input wire [3:0]         analog_cfg_pcfg_o,
    input wire               ext_bus_enabled_o
);
// ====
// Properties
default clocking cb @(posedge clk_i); endclocking
default disable iff (rst_i);
property p_ack; cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o; endproperty
a_ack: assert property (p_ack) else $error("bad ack");
property p_fin; (periph_force_in_i & ~small_pin_oe_n_o) == 0; endproperty
a_fin: assert property (p_fin) else $error("forced in driven");
property p_fout;
    (periph_force_out_i & ~periph_force_in_i & small_pin_oe_n_o) == 0;
endproperty
a_fout: assert property (p_fout) else $error("forced out float");
property p_fval;
    ((small_pin_o ^ periph_dout_i) & periph_force_out_i
        & ~periph_force_in_i) == 0;
endproperty
a_fval: assert property (p_fval) else $error("periph value");
property p_bus; ext_bus_enabled_o |-> wide_pin_oe_n_o[3:0] == 4'h0 &&
    wide_pin_o[3:0] == ext_address_high_bits_i; endproperty
a_bus: assert property (p_bus) else $error("address bits");
property p_ana;
    analog_cfg_pcfg_o != 4'hf |-> &wide_pin_oe_n_o[7:4];
endproperty
a_ana: assert property (p_ana) else $error("analog driven");
// Forced outputs are exempt: a peripheral may claim a pin at once.
property p_rst;
    $past(rst_i) |-> &(small_pin_oe_n_o | periph_force_out_i);
endproperty
a_rst: assert property (p_rst) else $error("reset dir");
property p_sync; !$past(rst_i) && !$past(rst_i, 2) |->
    periph_din_o == $past(small_pin_i, 2); endproperty
a_sync: assert property (p_sync) else $error("pin sync");
c_ack: cover property (ack_o);
c_dig: cover property (analog_cfg_pcfg_o == 4'hf);
c_frc: cover property (periph_force_in_i != 0);
endmodule
bind gpgh_port gpgh_asserts #(.SMALL_W(SMALL_W), .WIDE_W(WIDE_W))
    gpgh_asserts_i (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .ack_o(ack_o), .small_pin_i(small_pin_i),
    .small_pin_o(small_pin_o), .small_pin_oe_n_o(small_pin_oe_n_o),
    .periph_force_out_i(periph_force_out_i),
    .periph_force_in_i(periph_force_in_i),
    .periph_dout_i(periph_dout_i), .periph_din_o(periph_din_o),
    .wide_pin_o(wide_pin_o), .wide_pin_oe_n_o(wide_pin_oe_n_o),
    .ext_address_high_bits_i(ext_address_high_bits_i),
    .analog_cfg_pcfg_o(analog_cfg_pcfg_o),
    .ext_bus_enabled_o(ext_bus_enabled_o));

// ---- sim/gpgh_board.sv ----
// Board side of the pins: a level wherever the device lets go.
`timescale 1ns/1ps
module gpgh_board
#(parameter W = 5)
(
    input  wire [W-1:0] dev_i,
    input  wire [W-1:0] oe_n_i,
    input  wire [W-1:0] drv_i,
    output wire [W-1:0] lvl_o
);
assign lvl_o = (~oe_n_i & dev_i) | (oe_n_i & drv_i);
endmodule

// ---- sim/tb.sv ----
// Register-level testbench of the two-port GPIO.
`timescale 1ns/1ps
`include "gpgh_consts.vh"
module tb;
reg         clk_i = 1'h0, rst_i = 1'h1, cyc_i = 1'h0, stb_i = 1'h0;
reg         we_i = 1'h0;
reg  [7:0]  adr_i = 8'h0;
reg  [3:0]  sel_i = 4'h1, ext_address_high_bits_i = 4'h9;
reg  [31:0] dat_i = 32'h0;
reg  [4:0]  periph_force_out_i = 5'h0, periph_force_in_i = 5'h0;
reg  [4:0]  periph_dout_i = 5'h0;
wire [31:0] dat_o;
wire        ack_o, ext_bus_enabled_o;
wire [4:0]  small_pin_i, small_pin_o, small_pin_oe_n_o, periph_din_o;
wire [7:0]  wide_pin_i, wide_pin_o, wide_pin_oe_n_o;
wire [3:0]  analog_inputs_upper_o, analog_cfg_pcfg_o;
integer     failures = 0, num_checks = 0, i;
wire [8:0]  pin_mode = {ext_bus_enabled_o, analog_inputs_upper_o,
    analog_cfg_pcfg_o};
localparam [71:0] RV = 72'h000000ff00091f0015;
gpgh_port gpgh_port_i (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .small_pin_i(small_pin_i),
    .small_pin_o(small_pin_o), .small_pin_oe_n_o(small_pin_oe_n_o),
    .wide_pin_i(wide_pin_i), .wide_pin_o(wide_pin_o),
    .wide_pin_oe_n_o(wide_pin_oe_n_o),
    .periph_force_out_i(periph_force_out_i),
    .periph_force_in_i(periph_force_in_i),
    .periph_dout_i(periph_dout_i), .periph_din_o(periph_din_o),
    .ext_address_high_bits_i(ext_address_high_bits_i),
    .analog_inputs_upper_o(analog_inputs_upper_o),
    .analog_cfg_pcfg_o(analog_cfg_pcfg_o),
    .ext_bus_enabled_o(ext_bus_enabled_o));
gpgh_board #(.W(5)) small_board_i (.dev_i(small_pin_o),
    .oe_n_i(small_pin_oe_n_o), .drv_i(5'h15), .lvl_o(small_pin_i));
gpgh_board #(.W(8)) wide_board_i (.dev_i(wide_pin_o),
    .oe_n_i(wide_pin_oe_n_o), .drv_i(8'hff), .lvl_o(wide_pin_i));
// ====
// Tasks
task chk(input [31:0] g, input [31:0] e);
begin
    num_checks = num_checks + 1;
    if (g !== e)
    begin
        failures = failures + 1;
        $display("ERROR %0t got %h want %h", $time, g, e);
    end
end
endtask
// Reads compare at the ack edge; dat_o holds from the request edge until the next request.
task acc(input w, input [7:0] a, input [7:0] d);
begin
    @(posedge clk_i);
    cyc_i <= 1'h1;
    stb_i <= 1'h1;
    we_i <= w;
    adr_i <= a;
    dat_i <= {24'h0, d};
    @(posedge clk_i);
    while (ack_o !== 1'h1) @(posedge clk_i);
    cyc_i <= 1'h0;
    stb_i <= 1'h0;
    if (!w) chk(dat_o, {24'h0, d});
end
endtask
task end_sim;
begin
    $display("checks %0d errors %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
        $display("[ PASS ]");
    else
        $display("[ FAIL ]");
    $finish;
end
endtask
// ====
// Sequence
initial
begin
    forever #2.5 clk_i = ~clk_i;
end
initial
begin
    #20000;
    failures = failures + 1;
    end_sim;
end
initial
begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'h0;
    repeat (3) @(posedge clk_i);
    for (i = 0; i < 9; i = i + 1)
        acc(1'h0, 8'(4 * i), RV[8*i +: 8]);
    chk({23'h0, pin_mode}, 32'h1f0);
    acc(1'h1, `GPGH_OFF_SMALL_LATCH, 8'hff);
    acc(1'h0, `GPGH_OFF_SMALL_LATCH, 8'h1f);
    acc(1'h1, `GPGH_OFF_SMALL_DIR, 8'h00);
    acc(1'h1, `GPGH_OFF_SMALL_PINS, 8'h0a);
    acc(1'h0, `GPGH_OFF_SMALL_LATCH, 8'h0a);
    chk({22'h0, small_pin_oe_n_o, small_pin_o}, 32'h00a);
    sel_i <= 4'h0;
    acc(1'h1, `GPGH_OFF_SMALL_LATCH, 8'h15);
    sel_i <= 4'h1;
    periph_force_out_i <= 5'h03;
    periph_force_in_i <= 5'h04;
    periph_dout_i <= 5'h01;
    acc(1'h0, `GPGH_OFF_SMALL_DIR, 8'h00);
    acc(1'h0, `GPGH_OFF_SMALL_PINS, 8'h0d);
    chk({27'h0, periph_din_o}, 32'h0d);
    acc(1'h1, `GPGH_OFF_ANALOG_CFG, 8'h0f);
    acc(1'h1, `GPGH_OFF_MEM_CTRL, 8'h80);
    acc(1'h1, `GPGH_OFF_WIDE_DIR, 8'h0f);
    acc(1'h1, `GPGH_OFF_WIDE_LATCH, 8'ha5);
    repeat (2) @(posedge clk_i);
    acc(1'h0, `GPGH_OFF_WIDE_PINS, 8'haf);
    acc(1'h0, `GPGH_OFF_MEM_CTRL, 8'h80);
    chk({23'h0, pin_mode}, 32'h00f);
    acc(1'h1, `GPGH_OFF_ANALOG_CFG, 8'h0e);
    acc(1'h0, `GPGH_OFF_WIDE_PINS, 8'h0f);
    chk({23'h0, pin_mode}, 32'h0fe);
    rst_i <= 1'h1;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'h0;
    repeat (3) @(posedge clk_i);
    for (i = 0; i < 9; i = i + 1)
        acc(1'h0, 8'(4 * i), RV[8*i +: 8]);
    end_sim;
end
endmodule
